// ---- logic/mbagu_map.svh ----
// Register offsets, field positions and reset values of the address
// generator. Assumes byte addressing on a 32-bit Avalon-MM slave port.
`ifndef MBAGU_MAP_SVH
`define MBAGU_MAP_SVH

// Register byte offsets
`define MBAGU_OFS_MODE    8'h00
`define MBAGU_OFS_XSTART  8'h04
`define MBAGU_OFS_XEND    8'h08
`define MBAGU_OFS_YSTART  8'h0c
`define MBAGU_OFS_YEND    8'h10
`define MBAGU_OFS_BREV    8'h14
`define MBAGU_OFS_STATUS  8'h18

// Field positions in addr_mode_control
`define MBAGU_XSEL_LSB    0
`define MBAGU_YSEL_LSB    4
`define MBAGU_BSEL_LSB    8
`define MBAGU_YEN_BIT     14
`define MBAGU_XEN_BIT     15
// Field positions in bit_reverse_control
`define MBAGU_BITREV_ENABLE_BIT    15
`define MBAGU_PIVOT_MSB   14

// Pointer select value that means none
`define MBAGU_SEL_NONE    4'hf
// MAC prefetch pointer window and its indexed pointers
`define MBAGU_MAC_PLO     4'h8
`define MBAGU_MAC_PHI     4'hb
`define MBAGU_MAC_XIDX    4'h9
`define MBAGU_MAC_YIDX    4'hb

// Reset values
`define MBAGU_RST_MODE    16'h0fff
`define MBAGU_RST_ADDR    16'h0000
`define MBAGU_RST_BREV    16'h0000

`endif

// ---- logic/mbagu_pkg.sv ----
// Types shared by the address generator and its surroundings.
// Assumes the constants of mbagu_map.svh for all numbers.
package mbagu_pkg;

  typedef enum logic [1:0] {
    MBAGU_GEN_XRD,
    MBAGU_GEN_XWR,
    MBAGU_GEN_Y
  } mbagu_gen_t;

  typedef enum logic [1:0] {
    MBAGU_AM_IND,
    MBAGU_AM_POST,
    MBAGU_AM_PRE,
    MBAGU_AM_IDX
  } mbagu_am_t;

  typedef struct packed {
    logic        valid;
    mbagu_gen_t  gen;
    mbagu_am_t   mode;
    logic        mac;
    logic        byte_op;
    logic [3:0]  ptr_num;
    logic [15:0] ptr;
    logic [15:0] modif;
  } mbagu_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] ea;
    logic [15:0] ptr_new;
    logic [3:0]  ptr_num;
    logic        wb;
    logic        circ;
    logic        brev;
    logic        err;
  } mbagu_rsp_t;

endpackage

// ---- logic/mbagu_top.sv ----
// Modulo and bit-reversed address generator with its control registers.
// Assumes decode presents one request per cycle, synchronous to clk_i,
// and an Avalon-MM master that holds each access until waitrequest drops.
//
// How it works
// - MAC prefetch pointers are W8-W11, split X/Y
// - MAC indexed mode only via W9 and W11
// - MAC modes: indirect, post-mod +/-2/4/6, indexed
// - One circular buffer each in X and Y
// - Buffers of any length checked at both bounds
// - Buffer set by 16-bit start and end
// - Y effective addresses always word aligned
// - Select value 15 disables circular addressing
// - X circular needs select not 15, enable set
// - Y circular needs select not 15, enable set
// - Bound checks catch overshoot, not only equality
// - Corrected pointer written back only pre/post-modify
// - Bit reversal only in X write generator
// - Pivot added with reversed carry, pointer kept in normal order
// - Bit reversal needs select, enable, increment mode
// - Pivot field scaled to byte addresses
// - Byte writes and other modes stay unreversed
// - Reversed add ignores mode offset, clears LSb
// - Bit reversal beats circular in X writes
`include "mbagu_map.svh"

module mbagu_top
  import mbagu_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire mbagu_req_t  req_i,
  output mbagu_rsp_t       rsp_o
);

  logic [15:0] mode_q;
  logic [15:0] xstart_q;
  logic [15:0] xend_q;
  logic [15:0] ystart_q;
  logic [15:0] yend_q;
  logic [15:0] brev_q;
  logic        last_err_q;
  logic        req_take;

  logic [3:0]  xsel;
  logic [3:0]  ysel;
  logic [3:0]  bsel;
  logic        x_circ_en;
  logic        y_circ_en;
  logic        brev_en;
  logic        x_pow2;
  logic        y_pow2;

  logic [15:0] step;
  logic        inc;
  logic [15:0] sum;
  logic [15:0] target;
  logic [15:0] fixed;
  logic [15:0] lo;
  logic [15:0] hi;
  logic [15:0] len;
  logic [15:0] pivot_b;
  logic [15:0] rev_sum;
  logic        circ_on;
  logic        brev_on;
  logic        mac_err;
  mbagu_rsp_t  rsp_d;

  // Bit order reversal of a 16-bit word
  function automatic logic [15:0] rev16(input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++)
    begin
      r[i] = v[15 - i];
    end
    return r;
  endfunction

  // Power-of-two test on a buffer length
  function automatic logic is_pow2(input logic [15:0] v);
    return (v != 16'h0000) && ((v & (v - 16'h0001)) == 16'h0000);
  endfunction

  // Control field decode
  assign xsel      = mode_q[`MBAGU_XSEL_LSB +: 4];
  assign ysel      = mode_q[`MBAGU_YSEL_LSB +: 4];
  assign bsel      = mode_q[`MBAGU_BSEL_LSB +: 4];
  assign x_circ_en = (xsel != `MBAGU_SEL_NONE)
                     && mode_q[`MBAGU_XEN_BIT];
  assign y_circ_en = (ysel != `MBAGU_SEL_NONE)
                     && mode_q[`MBAGU_YEN_BIT];
  assign brev_en   = (bsel != `MBAGU_SEL_NONE) && brev_q[`MBAGU_BITREV_ENABLE_BIT];
  // Byte length of a word buffer, end word included
  assign x_pow2    = is_pow2(xend_q - xstart_q + 16'h0002);
  assign y_pow2    = is_pow2(yend_q - ystart_q + 16'h0002);

  // Bus handshake: one wait cycle, then a single-cycle answer
  assign req_take = (avs_read_i || avs_write_i) && !avs_waitrequest_o;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      avs_waitrequest_o <= 1'b1;
    else if ((avs_read_i || avs_write_i) && avs_waitrequest_o)
      avs_waitrequest_o <= 1'b0;
    else
      avs_waitrequest_o <= 1'b1;
  end

  // Register writes, low two byte lanes only; unmapped writes dropped
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      mode_q   <= `MBAGU_RST_MODE;
      xstart_q <= `MBAGU_RST_ADDR;
      xend_q   <= `MBAGU_RST_ADDR;
      ystart_q <= `MBAGU_RST_ADDR;
      yend_q   <= `MBAGU_RST_ADDR;
      brev_q   <= `MBAGU_RST_BREV;
    end
    else if (req_take && avs_write_i)
    begin
      for (int b = 0; b < 2; b++)
      begin
        if (avs_byteenable_i[b])
        begin
          if (avs_address_i == `MBAGU_OFS_MODE)
            mode_q[b*8 +: 8] <= avs_writedata_i[b*8 +: 8];
          else if (avs_address_i == `MBAGU_OFS_XSTART)
            xstart_q[b*8 +: 8] <= avs_writedata_i[b*8 +: 8];
          else if (avs_address_i == `MBAGU_OFS_XEND)
            xend_q[b*8 +: 8] <= avs_writedata_i[b*8 +: 8];
          else if (avs_address_i == `MBAGU_OFS_YSTART)
            ystart_q[b*8 +: 8] <= avs_writedata_i[b*8 +: 8];
          else if (avs_address_i == `MBAGU_OFS_YEND)
            yend_q[b*8 +: 8] <= avs_writedata_i[b*8 +: 8];
          else if (avs_address_i == `MBAGU_OFS_BREV)
            brev_q[b*8 +: 8] <= avs_writedata_i[b*8 +: 8];
        end
      end
    end
  end

  // Read data, presented with the falling waitrequest
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      avs_readdata_o <= 32'h0000_0000;
    else if (avs_read_i && avs_waitrequest_o)
    begin
      if (avs_address_i == `MBAGU_OFS_MODE)
        avs_readdata_o <= {16'h0000, mode_q};
      else if (avs_address_i == `MBAGU_OFS_XSTART)
        avs_readdata_o <= {16'h0000, xstart_q};
      else if (avs_address_i == `MBAGU_OFS_XEND)
        avs_readdata_o <= {16'h0000, xend_q};
      else if (avs_address_i == `MBAGU_OFS_YSTART)
        avs_readdata_o <= {16'h0000, ystart_q};
      else if (avs_address_i == `MBAGU_OFS_YEND)
        avs_readdata_o <= {16'h0000, yend_q};
      else if (avs_address_i == `MBAGU_OFS_BREV)
        avs_readdata_o <= {16'h0000, brev_q};
      else if (avs_address_i == `MBAGU_OFS_STATUS)
        avs_readdata_o <= {26'h0, last_err_q, y_pow2, x_pow2,
                           brev_en, y_circ_en, x_circ_en};
      else
        avs_readdata_o <= 32'h0000_0000;
    end
  end

  // Effective address datapath for the current request
  always_comb
  begin
    step    = req_i.modif;
    inc     = !step[15];
    sum     = req_i.ptr + step;
    // One buffer per space; both X generators share the X one
    lo      = (req_i.gen == MBAGU_GEN_Y) ? ystart_q : xstart_q;
    hi      = (req_i.gen == MBAGU_GEN_Y) ? yend_q : xend_q;
    len     = hi - lo + 16'h0002;
    // Pivot counts words, addresses count bytes
    pivot_b = {brev_q[`MBAGU_PIVOT_MSB:0], 1'b0};
    // Reversed-carry add of the pivot onto the pointer
    rev_sum = rev16(rev16(req_i.ptr) + rev16(pivot_b));

    brev_on = (req_i.gen == MBAGU_GEN_XWR) && brev_en
              && (req_i.ptr_num == bsel) && !req_i.byte_op
              && (req_i.mode == MBAGU_AM_PRE
                  || req_i.mode == MBAGU_AM_POST) && inc;
    if (req_i.gen == MBAGU_GEN_Y)
      circ_on = y_circ_en && (req_i.ptr_num == ysel);
    else if (req_i.gen == MBAGU_GEN_XWR)
      circ_on = x_circ_en && (req_i.ptr_num == xsel) && !brev_en;
    else
      circ_on = x_circ_en && (req_i.ptr_num == xsel);

    // MAC operand fetch restrictions
    mac_err = 1'b0;
    if (req_i.mac)
    begin
      if (req_i.ptr_num < `MBAGU_MAC_PLO || req_i.ptr_num > `MBAGU_MAC_PHI)
        mac_err = 1'b1;
      else if ((req_i.ptr_num[1] == 1'b0) != (req_i.gen == MBAGU_GEN_XRD))
        mac_err = 1'b1;
      if (req_i.mode == MBAGU_AM_IDX && req_i.ptr_num != `MBAGU_MAC_XIDX
          && req_i.ptr_num != `MBAGU_MAC_YIDX)
        mac_err = 1'b1;
      if (req_i.mode == MBAGU_AM_PRE)
        mac_err = 1'b1;
      if (req_i.mode == MBAGU_AM_POST && step != 16'h0002
          && step != 16'h0004 && step != 16'h0006 && step != 16'hfffe
          && step != 16'hfffc && step != 16'hfffa)
        mac_err = 1'b1;
    end

    // Bound checks catch any overshoot, then wrap by the length
    target = (req_i.mode == MBAGU_AM_IND) ? req_i.ptr : sum;
    fixed  = target;
    if (circ_on && req_i.mode != MBAGU_AM_IND)
    begin
      if (inc && target > hi)
        fixed = target - len;
      else if (!inc && target < lo)
        fixed = target + len;
    end

    rsp_d         = '0;
    rsp_d.valid   = req_i.valid;
    rsp_d.ptr_num = req_i.ptr_num;
    rsp_d.err     = mac_err;
    rsp_d.circ    = circ_on && !brev_on;
    rsp_d.brev    = brev_on;
    rsp_d.ptr_new = req_i.ptr;
    rsp_d.ea      = fixed;
    if (brev_on)
    begin
      // Mode offset ignored; pointer plus reversed pivot only
      rsp_d.ptr_new = rev_sum & 16'hfffe;
      rsp_d.ea      = (req_i.mode == MBAGU_AM_PRE) ?
                      (rev_sum & 16'hfffe) : (req_i.ptr & 16'hfffe);
      rsp_d.wb      = !mac_err;
    end
    else if (req_i.mode == MBAGU_AM_POST)
    begin
      rsp_d.ea      = req_i.ptr;
      rsp_d.ptr_new = fixed;
      rsp_d.wb      = !mac_err;
    end
    else if (req_i.mode == MBAGU_AM_PRE)
    begin
      rsp_d.ptr_new = fixed;
      rsp_d.wb      = !mac_err;
    end
    // Indexed: address corrected, pointer left alone
    // A rejected fetch still reports, but never moves the pointer
    if (mac_err)
      rsp_d.ptr_new = req_i.ptr;
    // Y space works on words only
    if (req_i.gen == MBAGU_GEN_Y)
    begin
      rsp_d.ea[0]      = 1'b0;
      rsp_d.ptr_new[0] = 1'b0;
    end
    if (!req_i.valid)
      rsp_d.wb = 1'b0;
  end

  // Result register, one cycle after the request
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      rsp_o <= '0;
    else
      rsp_o <= rsp_d;
  end

  // Sticky-free flag of the latest request's MAC check
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      last_err_q <= 1'b0;
    else if (req_i.valid)
      last_err_q <= mac_err;
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_mac_ptr_range: assert property (
    req_i.valid && req_i.mac && req_i.ptr_num < 4'h8 |=> rsp_o.err)
    else $error("MAC pointer below W8 accepted");
  a_mac_idx_only: assert property (
    req_i.valid && req_i.mac && req_i.mode == MBAGU_AM_IDX
    && req_i.ptr_num == 4'h8 |=> rsp_o.err && !rsp_o.wb)
    else $error("MAC indexed via W8 accepted");
  a_mac_no_pre: assert property (
    req_i.valid && req_i.mac && req_i.mode == MBAGU_AM_PRE |=> rsp_o.err)
    else $error("MAC pre-modify accepted");
  a_y_word_ea: assert property (
    $past(req_i.valid && req_i.gen == MBAGU_GEN_Y) |-> rsp_o.ea[0] == 1'b0)
    else $error("Y address not word aligned");
  a_circ_sel_off: assert property (
    mode_q[3:0] == 4'hf && req_i.gen != MBAGU_GEN_Y |=> !rsp_o.circ)
    else $error("X circular with select 15");
  a_idx_no_wb: assert property (
    req_i.mode == MBAGU_AM_IDX |=> !rsp_o.wb)
    else $error("Indexed mode wrote pointer back");
  a_wrap_in_range: assert property (
    req_i.valid && circ_on && !brev_on && req_i.mode == MBAGU_AM_POST
    && req_i.ptr >= lo && req_i.ptr <= hi && inc && step < len
    |=> rsp_o.ptr_new >= $past(lo) && rsp_o.ptr_new <= $past(hi) + 16'h0001)
    else $error("Wrapped pointer left buffer");
  a_brev_xwr_only: assert property (
    req_i.gen != MBAGU_GEN_XWR |=> !rsp_o.brev)
    else $error("Bit reversal outside X writes");
  a_brev_byte_off: assert property (
    req_i.byte_op |=> !rsp_o.brev)
    else $error("Bit reversal on byte write");
  a_brev_lsb_zero: assert property (
    rsp_o.brev |-> rsp_o.ea[0] == 1'b0 && rsp_o.ptr_new[0] == 1'b0)
    else $error("Bit-reversed address odd");
  a_brev_wins: assert property (
    brev_en && req_i.gen == MBAGU_GEN_XWR |=> !rsp_o.circ)
    else $error("Circular active in X write with reversal");
  a_bus_answer: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("Bus answer not one cycle");

  c_circ_wrap: cover property (rsp_o.circ && rsp_o.wb
    && rsp_o.ptr_new != $past(sum));
  c_brev_post: cover property (rsp_o.brev && rsp_o.wb);
  c_mac_err: cover property (rsp_o.err);
  c_reg_write: cover property (avs_write_i && !avs_waitrequest_o);

endmodule

// ---- test/mbagu_core_model.sv ----
// Model of the decode stage and pointer file that feed the generator.
// Assumes the bench hands it one request per cycle on cmd_i.
module mbagu_core_model
  import mbagu_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire mbagu_req_t cmd_i,
  input  wire mbagu_rsp_t rsp_i,
  output mbagu_req_t      req_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] rf_q [16];

  // Request leaves just after the edge the bench set it on
  assign req_o = cmd_i;

  // Corrected pointers land in the file only when flagged
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      for (int i = 0; i < 16; i++)
        rf_q[i] <= 16'h0000;
    end
    else if (rsp_i.valid && rsp_i.wb)
    begin
      rf_q[rsp_i.ptr_num] <= rsp_i.ptr_new;
    end
  end
endmodule

// ---- test/modulo_bitrev_agu_tb_top.sv ----
// Self-checking bench for the modulo and bit-reversed generator.
// Assumes mbagu_top, its package and the core model beside it.
`include "mbagu_map.svh"
module modulo_bitrev_agu_tb_top
  import mbagu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    mbagu_req_t  q;
    logic [15:0] ea;
    logic [15:0] np;
    logic [2:0]  f;
  } mbagu_row_t;

  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        wait_rq;
  mbagu_req_t  cmd = '0;
  mbagu_req_t  req;
  mbagu_rsp_t  rsp;
  mbagu_row_t  rows [19];
  int          n_errors = 0;
  int          check_count = 0;
  int          cyc = 0;

  // Clock and hang guard
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_errors++;
      print_verdict();
    end
  end

  mbagu_top dut (
    .clk_i            (clk_i),
    .srst_i           (srst_i),
    .avs_address_i    (adr),
    .avs_read_i       (rd),
    .avs_write_i      (wr),
    .avs_writedata_i  (wdat),
    .avs_byteenable_i (4'h3),
    .avs_readdata_o   (rdat),
    .avs_waitrequest_o(wait_rq),
    .req_i            (req),
    .rsp_o            (rsp)
  );

  mbagu_core_model mdl (
    .clk_i (clk_i),
    .srst_i(srst_i),
    .cmd_i (cmd),
    .rsp_i (rsp),
    .req_o (req)
  );

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [63:0] got, exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    adr <= a;
    wdat <= d;
    rd <= !w;
    wr <= w;
    do @(posedge clk_i); while (wait_rq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    cmp(q, e, "register");
  endtask

  function automatic mbagu_row_t mk(input mbagu_gen_t g,
    input mbagu_am_t m, input logic [1:0] mb, input logic [3:0] n,
    input logic [15:0] p, md, ea, np, input logic [2:0] f);
    mk.q = '{1'b1, g, m, mb[1], mb[0], n, p, md};
    mk.ea = ea;
    mk.np = np;
    mk.f = f;
  endfunction

  // One request, result looked at in the cycle it stands
  task automatic run(input mbagu_row_t r);
    @(posedge clk_i);
    cmd <= r.q;
    @(posedge clk_i);
    cmd <= '0;
    #1;
    cmp({rsp.wb, rsp.err, rsp.brev}, r.f, "flags");
    cmp({rsp.valid, rsp.ptr_num}, {1'b1, r.q.ptr_num}, "result id");
    if (!r.f[1])
      cmp(rsp.ea, r.ea, "address");
    if (r.f[2] || r.f[1])
      cmp(rsp.ptr_new, r.np, "pointer");
  endtask

  // Base 0x0800 keeps the low bits of the reversed buffer clear
  initial
  begin
    rows[0] = mk(MBAGU_GEN_XRD, MBAGU_AM_POST, 0, 1, 'h100e, 2,
                 'h100e, 'h1000, 3'b100);
    rows[1] = mk(MBAGU_GEN_XRD, MBAGU_AM_PRE, 0, 1, 'h100c, 4,
                 'h1000, 'h1000, 3'b100);
    rows[2] = mk(MBAGU_GEN_XRD, MBAGU_AM_POST, 0, 1, 'h1000, 'hfffe,
                 'h1000, 'h100e, 3'b100);
    rows[3] = mk(MBAGU_GEN_XRD, MBAGU_AM_IDX, 0, 1, 'h100c, 6,
                 'h1002, 0, 3'b000);
    rows[4] = mk(MBAGU_GEN_Y, MBAGU_AM_POST, 0, 10, 'h201e, 2,
                 'h201e, 'h2000, 3'b100);
    rows[5] = mk(MBAGU_GEN_Y, MBAGU_AM_IND, 0, 5, 'h2003, 0,
                 'h2002, 0, 3'b000);
    rows[6] = mk(MBAGU_GEN_XWR, MBAGU_AM_POST, 0, 2, 'h0810, 2,
                 'h0810, 'h0808, 3'b101);
    rows[7] = mk(MBAGU_GEN_XWR, MBAGU_AM_PRE, 0, 2, 'h0808, 6,
                 'h0818, 'h0818, 3'b101);
    rows[8] = mk(MBAGU_GEN_XWR, MBAGU_AM_POST, 1, 2, 'h0811, 1,
                 'h0811, 'h0812, 3'b100);
    rows[9] = mk(MBAGU_GEN_XWR, MBAGU_AM_IND, 0, 2, 'h0810, 2,
                 'h0810, 0, 3'b000);
    rows[10] = mk(MBAGU_GEN_XRD, MBAGU_AM_PRE, 0, 2, 'h0810, 2,
                  'h0812, 'h0812, 3'b100);
    rows[11] = mk(MBAGU_GEN_XRD, MBAGU_AM_POST, 2, 8, 'h0400, 4,
                  'h0400, 'h0404, 3'b100);
    rows[12] = mk(MBAGU_GEN_Y, MBAGU_AM_POST, 2, 11, 'h0400, 'hfffa,
                  'h0400, 'h03fa, 3'b100);
    rows[13] = mk(MBAGU_GEN_XRD, MBAGU_AM_IDX, 2, 9, 'h0400, 4,
                  'h0404, 0, 3'b000);
    rows[14] = mk(MBAGU_GEN_XRD, MBAGU_AM_IDX, 2, 8, 'h0400, 4,
                  0, 'h0400, 3'b010);
    rows[15] = mk(MBAGU_GEN_Y, MBAGU_AM_POST, 2, 8, 'h0400, 2,
                  0, 'h0400, 3'b010);
    rows[16] = mk(MBAGU_GEN_XRD, MBAGU_AM_PRE, 2, 9, 'h0400, 2,
                  0, 'h0400, 3'b010);
    rows[17] = mk(MBAGU_GEN_XRD, MBAGU_AM_POST, 2, 9, 'h0400, 8,
                  0, 'h0400, 3'b010);
    rows[18] = mk(MBAGU_GEN_XRD, MBAGU_AM_POST, 2, 5, 'h0400, 2,
                  0, 'h0400, 3'b010);
    repeat (9) @(posedge clk_i);
    #1;
    cmp(wait_rq, 1'b1, "reset wait");
    cmp(rsp, '0, "reset result");
    @(posedge clk_i);
    srst_i <= 1'b0;
    rreg(`MBAGU_OFS_MODE, 32'h0fff);
    rreg(`MBAGU_OFS_BREV, 32'h0);
    rreg(`MBAGU_OFS_XSTART, 32'h0);
    wreg(`MBAGU_OFS_STATUS, 32'hff);
    // Empty buffers are two bytes long, so both report power of two
    rreg(`MBAGU_OFS_STATUS, 32'h18);
    rreg(8'h1c, 32'h0);
    // Pointer 15 never serves as a circular pointer; pointer 14 still can
    wreg(`MBAGU_OFS_XSTART, 32'h1000);
    wreg(`MBAGU_OFS_XEND, 32'hffff100e);
    wreg(`MBAGU_OFS_YSTART, 32'h2000);
    wreg(`MBAGU_OFS_YEND, 32'h201e);
    wreg(`MBAGU_OFS_BREV, 32'h8008);
    wreg(`MBAGU_OFS_MODE, 32'hc2a1);
    rreg(`MBAGU_OFS_XEND, 32'h100e);
    rreg(`MBAGU_OFS_STATUS, 32'h1f);
    foreach (rows[i])
      run(rows[i]);
    // Last valid request was a rejected MAC fetch
    rreg(`MBAGU_OFS_STATUS, 32'h3f);
    // Bit reversal and circular both aimed at pointer 2
    wreg(`MBAGU_OFS_MODE, 32'hc2a2);
    run(mk(MBAGU_GEN_XWR, MBAGU_AM_POST, 0, 2, 'h0810, 2,
           'h0810, 'h0808, 3'b101));
    cmp(rsp.circ, 1'b0, "circ in X write");
    run(mk(MBAGU_GEN_XRD, MBAGU_AM_POST, 0, 2, 'h100e, 2,
           'h100e, 'h1000, 3'b100));
    cmp(rsp.circ, 1'b1, "circ in X read");
    // Select 15 leaves X addresses unwrapped
    wreg(`MBAGU_OFS_MODE, 32'hc2af);
    run(mk(MBAGU_GEN_XRD, MBAGU_AM_POST, 0, 1, 'h100e, 2,
           'h100e, 'h1010, 3'b100));
    cmp(rsp.circ, 1'b0, "circ read select 15");
    run(mk(MBAGU_GEN_XWR, MBAGU_AM_POST, 0, 1, 'h100e, 2,
           'h100e, 'h1010, 3'b100));
    cmp(rsp.circ, 1'b0, "circ write select 15");
    // Enable off; no read follows the rewrite through pointer 2
    wreg(`MBAGU_OFS_BREV, 32'h0008);
    run(mk(MBAGU_GEN_XWR, MBAGU_AM_POST, 0, 2, 'h0810, 2,
           'h0810, 'h0812, 3'b100));
    // Written-back pointers land in the core's file one edge later
    @(posedge clk_i);
    #1;
    cmp(mdl.rf_q[2], 16'h0812, "pointer file");
    cmp(mdl.rf_q[1], 16'h1010, "pointer file");
    print_verdict();
  end
endmodule
